// ### core/gszcr_map.svh
// Register offsets, field positions and reset values of the configuration bank.
`ifndef GSZCR_MAP_SVH
`define GSZCR_MAP_SVH
`define GSZCR_ADDR_PIN_CFG     8'h05
`define GSZCR_ADDR_DIR_CFG     8'h07
`define GSZCR_ADDR_OUT_LEVEL   8'h0B
`define GSZCR_ADDR_IN_LEVEL    8'h0D
`define GSZCR_ADDR_BLANK_CFG   8'h0F
`define GSZCR_ADDR_SEQ_CFG     8'h10
`define GSZCR_ADDR_CHAN_SEL    8'h11
`define GSZCR_ADDR_SCAN_EN     8'h12
`define GSZCR_RESET_VALUE      8'h00
`define GSZCR_SEQ_CFG_MASK     8'h13
`define GSZCR_SEQUENCE_START_BIT_BIT    4
`define GSZCR_MULT_BIT         7
`define GSZCR_MULT_SHIFT       3
`define GSZCR_CHAN_LAST        4'h7
`endif

// ### core/gszcr_pkg.sv
// Types shared by the configuration bank.
`default_nettype none
package gszcr_pkg;
    typedef enum logic [1:0] {
        GSZCR_SCAN_MANUAL = 2'b00,
        GSZCR_SCAN_AUTO   = 2'b01,
        GSZCR_SCAN_FLY    = 2'b10,
        GSZCR_SCAN_RSVD   = 2'b11
    } gszcr_scan_t;
    typedef enum logic [1:0] {
        GSZCR_BL_IDLE  = 2'b00,
        GSZCR_BL_BLANK = 2'b01
    } gszcr_blank_t;
endpackage
`default_nettype wire

// ### core/gszcr_blanker.sv
// Zero-crossing source selection and post-event blanking counter.
`timescale 1ns/100ps
`default_nettype none
`include "gszcr_map.svh"
module gszcr_blanker (
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    // Configuration
    input  wire logic [7:0] blank_cfg_i,
    input  wire logic       src_is_pin_i,
    input  wire logic       src_pin_level_i,
    // Conversion results of the source channel
    input  wire logic       conv_done_i,
    input  wire logic       conv_above_i,
    // Event output
    output logic            event_o,
    output logic            blanking_o
);
    gszcr_pkg::gszcr_blank_t state_reg;
    gszcr_pkg::gszcr_blank_t state_next;
    logic [9:0] count_reg;
    logic [9:0] count_next;
    logic       level_reg;
    logic       level_next;
    logic       event_next;
    logic       cur_level;
    logic [9:0] load;

    always_comb begin
        // Pin level is used directly, else the comparator result.
        cur_level = src_is_pin_i ? src_pin_level_i : level_reg;
        if (!src_is_pin_i && conv_done_i) begin
            cur_level = conv_above_i;
        end
        if (blank_cfg_i[`GSZCR_MULT_BIT]) begin
            load = {blank_cfg_i[6:0], 3'h0};
        end else begin
            load = {3'h0, blank_cfg_i[6:0]};
        end
        state_next = state_reg;
        count_next = count_reg;
        level_next = cur_level;
        event_next = 1'b0;
        case (state_reg)
            gszcr_pkg::GSZCR_BL_IDLE: begin
                if (cur_level != level_reg) begin
                    event_next = 1'b1;
                    // Counting starts with the next source conversion, not the event itself.
                    count_next = load;
                    if (load != 10'h000) begin
                        state_next = gszcr_pkg::GSZCR_BL_BLANK;
                    end
                end
            end
            gszcr_pkg::GSZCR_BL_BLANK: begin
                // Level tracking continues; edges are swallowed.
                if (conv_done_i) begin
                    count_next = count_reg - 10'h001;
                    if (count_reg == 10'h001) begin
                        state_next = gszcr_pkg::GSZCR_BL_IDLE;
                    end
                end
            end
            default: begin
                state_next = gszcr_pkg::GSZCR_BL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg <= gszcr_pkg::GSZCR_BL_IDLE;
            count_reg <= 10'h000;
            level_reg <= 1'b0;
            event_o   <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            level_reg <= level_next;
            event_o   <= event_next;
        end
    end
    assign blanking_o = (state_reg == gszcr_pkg::GSZCR_BL_BLANK);

    a_blank_holds_off: assert property (@(posedge clk_sys_i)
        disable iff (reset_i)
        blanking_o |=> !event_o)
        else $error("Event raised during blanking.");
    a_blank_load_mult: assert property (@(posedge clk_sys_i)
        disable iff (reset_i)
        (state_reg == gszcr_pkg::GSZCR_BL_IDLE && event_next
         && load != 10'h000)
        |=> count_reg == $past(load))
        else $error("Blanking count loaded wrongly.");
endmodule
`default_nettype wire

// ### core/gszcr_regs.sv
// Configuration register bank: pin levels, blanking, sequencing, channels.
// Summary of operation
// - Each output-level bit drives its output channel: 0 low, 1 high.
// - Reading the input-level register returns the eight pin levels.
// - Blanking count is the field, or eight times it with the multiplier.
// - After a crossing event, that many source conversions are ignored.
// - In auto mode, start 1 scans enabled analog channels ascending, 0 stops.
// - The mode field picks manual, auto, on-the-fly or reserved scanning.
// - In manual mode the channel field picks inputs 0..7; 1000b reserved.
// - An analog crossing source derives crossings from threshold compares.
// - A digital-input crossing source uses the pin level directly.
// - Reserved sequencing bits read back as zero.
// - A pin-config bit of 0 makes the channel analog, 1 a digital pin.
// - A direction bit of 0 makes the pin an input, 1 an output.
// - A scan-enable bit of 1 includes the channel in the auto scan if its pin-config bit is 0.
`timescale 1ns/100ps
`default_nettype none
`include "gszcr_map.svh"
module gszcr_regs #(
    parameter int CHANNELS = 8
) (
    // Clock and reset
    input  wire logic                clk_sys_i,
    input  wire logic                reset_i,
    // Register port from the serial interface
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    input  wire logic [7:0]          reg_addr_i,
    input  wire logic [7:0]          reg_wdata_i,
    output logic      [7:0]          reg_rdata_o,
    // Channel pins
    input  wire logic [CHANNELS-1:0] pin_level_i,
    output logic      [CHANNELS-1:0] pin_out_o,
    output logic      [CHANNELS-1:0] pin_oe_o,
    // Conversion datapath
    input  wire logic                conv_done_i,
    input  wire logic                conv_above_i,
    output logic      [3:0]          conv_channel_o,
    output logic                     conv_channel_valid_o,
    output logic      [1:0]          scan_method_o,
    output logic                     scan_run_o,
    output logic      [CHANNELS-1:0] scan_channel_enable_o,
    // Crossing detector
    output logic                     zero_crossing_detect_o
);
    logic [7:0] pin_cfg_reg, pin_cfg_next;
    logic [7:0] dir_cfg_reg, dir_cfg_next;
    logic [7:0] out_level_reg, out_level_next;
    logic [7:0] in_level_reg;
    logic [7:0] blank_reg, blank_next;
    logic [7:0] seq_reg, seq_next;
    logic [7:0] chan_reg, chan_next;
    logic [7:0] scan_en_reg, scan_en_next;
    logic [7:0] rdata_next;
    logic [3:0] scan_ch_reg, scan_ch_next;
    logic [3:0] conv_ch_next;
    logic       conv_valid_next;
    logic [CHANNELS-1:0] out_next, oe_next;
    logic       seq_go;
    logic [3:0] src_ch;
    logic       src_is_pin;
    logic       crossing_evt;
    logic       zcd_next;

    always_comb begin
        pin_cfg_next   = pin_cfg_reg;
        dir_cfg_next   = dir_cfg_reg;
        out_level_next = out_level_reg;
        blank_next     = blank_reg;
        seq_next       = seq_reg;
        chan_next      = chan_reg;
        scan_en_next   = scan_en_reg;
        if (reg_wr_i) begin
            case (reg_addr_i)
                `GSZCR_ADDR_PIN_CFG:   pin_cfg_next   = reg_wdata_i;
                `GSZCR_ADDR_DIR_CFG:   dir_cfg_next   = reg_wdata_i;
                `GSZCR_ADDR_OUT_LEVEL: out_level_next = reg_wdata_i;
                `GSZCR_ADDR_BLANK_CFG: blank_next     = reg_wdata_i;
                // Reserved bits are masked off on the way in.
                `GSZCR_ADDR_SEQ_CFG:
                    seq_next = reg_wdata_i & `GSZCR_SEQ_CFG_MASK;
                `GSZCR_ADDR_CHAN_SEL:  chan_next      = reg_wdata_i;
                `GSZCR_ADDR_SCAN_EN:   scan_en_next   = reg_wdata_i;
                default: ; // Input-level and unknown writes drop.
            endcase
        end
        case (reg_addr_i)
            `GSZCR_ADDR_PIN_CFG:   rdata_next = pin_cfg_reg;
            `GSZCR_ADDR_DIR_CFG:   rdata_next = dir_cfg_reg;
            `GSZCR_ADDR_OUT_LEVEL: rdata_next = out_level_reg;
            `GSZCR_ADDR_IN_LEVEL:  rdata_next = in_level_reg;
            `GSZCR_ADDR_BLANK_CFG: rdata_next = blank_reg;
            `GSZCR_ADDR_SEQ_CFG:   rdata_next = seq_reg;
            `GSZCR_ADDR_CHAN_SEL:  rdata_next = chan_reg;
            `GSZCR_ADDR_SCAN_EN:   rdata_next = scan_en_reg;
            default:               rdata_next = `GSZCR_RESET_VALUE;
        endcase
        if (!reg_rd_i) begin
            rdata_next = reg_rdata_o;
        end
    end

    // Pin drive: only general-purpose pins set as outputs are driven.
    for (genvar i = 0; i < CHANNELS; i++) begin : g_pin
        always_comb begin
            oe_next[i]  = pin_cfg_reg[i] & dir_cfg_reg[i];
            out_next[i] = out_level_reg[i];
        end
    end

    // Scan channel selection.
    assign seq_go = (seq_reg[1:0] == gszcr_pkg::GSZCR_SCAN_AUTO)
                    && seq_reg[`GSZCR_SEQUENCE_START_BIT_BIT];
    always_comb begin
        logic [3:0] cand;
        logic       found;
        cand = scan_ch_reg;
        found = 1'b0;
        scan_ch_next = scan_ch_reg;
        // Step to the next enabled analog channel, wrapping upward.
        // A disabled pointer moves on at once, else the scan would wait
        // for a conversion that is never requested.
        if (seq_go && (conv_done_i || !(scan_en_reg[scan_ch_reg[2:0]]
                       && !pin_cfg_reg[scan_ch_reg[2:0]]))) begin
            for (int k = 1; k <= CHANNELS; k++) begin
                cand = 4'((32'(scan_ch_reg) + k) % CHANNELS);
                if (!found && scan_en_reg[cand[2:0]]
                    && !pin_cfg_reg[cand[2:0]]) begin
                    scan_ch_next = cand;
                    found = 1'b1;
                end
            end
        end else if (!seq_go) begin
            scan_ch_next = 4'h0; // Restart at the lowest channel.
        end
        case (seq_reg[1:0])
            gszcr_pkg::GSZCR_SCAN_MANUAL: begin
                conv_ch_next = chan_reg[3:0];
                // Code 1000b and above are reserved; no valid conversion.
                conv_valid_next = (chan_reg[3:0] <= `GSZCR_CHAN_LAST);
            end
            gszcr_pkg::GSZCR_SCAN_AUTO: begin
                conv_ch_next = scan_ch_reg;
                conv_valid_next = seq_go && scan_en_reg[scan_ch_reg[2:0]]
                                  && !pin_cfg_reg[scan_ch_reg[2:0]];
            end
            default: begin
                // On-the-fly and reserved modes pass the channel field on; never valid.
                conv_ch_next = chan_reg[3:0];
                conv_valid_next = 1'b0;
            end
        endcase
    end

    // Crossing source: pin level is used only for general-purpose inputs.
    assign src_ch = chan_reg[7:4];
    assign src_is_pin = pin_cfg_reg[src_ch[2:0]]
                        && !dir_cfg_reg[src_ch[2:0]];

    gszcr_blanker u_blanker (
        .clk_sys_i       (clk_sys_i),
        .reset_i         (reset_i),
        .blank_cfg_i     (blank_reg),
        .src_is_pin_i    (src_is_pin),
        .src_pin_level_i (in_level_reg[src_ch[2:0]]),
        .conv_done_i     (conv_done_i && conv_ch_next == src_ch),
        .conv_above_i    (conv_above_i),
        .event_o         (crossing_evt),
        .blanking_o      ()
    );
    assign zcd_next = zero_crossing_detect_o ^ crossing_evt;

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            pin_cfg_reg            <= `GSZCR_RESET_VALUE;
            dir_cfg_reg            <= `GSZCR_RESET_VALUE;
            out_level_reg          <= `GSZCR_RESET_VALUE;
            in_level_reg           <= `GSZCR_RESET_VALUE;
            blank_reg              <= `GSZCR_RESET_VALUE;
            seq_reg                <= `GSZCR_RESET_VALUE;
            chan_reg               <= `GSZCR_RESET_VALUE;
            scan_en_reg            <= `GSZCR_RESET_VALUE;
            reg_rdata_o            <= `GSZCR_RESET_VALUE;
            scan_ch_reg            <= 4'h0;
            pin_out_o              <= '0;
            pin_oe_o               <= '0;
            conv_channel_o         <= 4'h0;
            conv_channel_valid_o   <= 1'b0;
            scan_method_o          <= 2'h0;
            scan_run_o             <= 1'b0;
            scan_channel_enable_o  <= '0;
            zero_crossing_detect_o <= 1'b0;
        end else begin
            pin_cfg_reg            <= pin_cfg_next;
            dir_cfg_reg            <= dir_cfg_next;
            out_level_reg          <= out_level_next;
            in_level_reg           <= pin_level_i;
            blank_reg              <= blank_next;
            seq_reg                <= seq_next;
            chan_reg               <= chan_next;
            scan_en_reg            <= scan_en_next;
            reg_rdata_o            <= rdata_next;
            scan_ch_reg            <= scan_ch_next;
            pin_out_o              <= out_next;
            pin_oe_o               <= oe_next;
            conv_channel_o         <= conv_ch_next;
            conv_channel_valid_o   <= conv_valid_next;
            scan_method_o          <= seq_reg[1:0];
            scan_run_o             <= seq_go;
            scan_channel_enable_o  <= scan_en_reg;
            zero_crossing_detect_o <= zcd_next;
        end
    end

    a_seq_reserved_zero: assert property (@(posedge clk_sys_i)
        disable iff (reset_i)
        (seq_reg & ~`GSZCR_SEQ_CFG_MASK) == 8'h00)
        else $error("Reserved sequencing bits set.");
    sequence s_out_write;
        reg_wr_i && reg_addr_i == `GSZCR_ADDR_OUT_LEVEL;
    endsequence
    a_out_level_drive: assert property (@(posedge clk_sys_i)
        disable iff (reset_i)
        s_out_write |=> ##1 pin_out_o == $past(reg_wdata_i, 2))
        else $error("Output level not driven.");
    a_in_level_read: assert property (@(posedge clk_sys_i)
        disable iff (reset_i)
        reg_rd_i && reg_addr_i == `GSZCR_ADDR_IN_LEVEL
        |=> reg_rdata_o == $past(in_level_reg))
        else $error("Input level readback wrong.");
    a_in_level_ro: assert property (@(posedge clk_sys_i)
        disable iff (reset_i)
        reg_wr_i && reg_addr_i == `GSZCR_ADDR_IN_LEVEL
        |=> in_level_reg == $past(pin_level_i) && $stable(out_level_reg)
            && $stable(seq_reg) && $stable(chan_reg))
        else $error("Input level register written.");
    a_start_runs_scan: assert property (@(posedge clk_sys_i)
        disable iff (reset_i)
        reg_wr_i && reg_addr_i == `GSZCR_ADDR_SEQ_CFG
        && reg_wdata_i[1:0] == 2'b01 && reg_wdata_i[4]
        |=> ##1 scan_run_o)
        else $error("Auto scan did not start.");
    a_stop_halts_scan: assert property (@(posedge clk_sys_i)
        disable iff (reset_i)
        reg_wr_i && reg_addr_i == `GSZCR_ADDR_SEQ_CFG && !reg_wdata_i[4]
        |=> ##1 !scan_run_o)
        else $error("Auto scan did not stop.");
    a_manual_reserved: assert property (@(posedge clk_sys_i)
        disable iff (reset_i)
        seq_reg[1:0] == 2'b00 && chan_reg[3]
        |=> !conv_channel_valid_o)
        else $error("Reserved manual channel accepted.");
    a_pin_drive_gate: assert property (@(posedge clk_sys_i)
        disable iff (reset_i)
        !pin_cfg_reg[0] |=> !pin_oe_o[0])
        else $error("Analog channel driven.");
endmodule
`default_nettype wire

// ### testbench/gszcr_host_model.sv
// Host processor model that drives the register port of the bank.
`timescale 1ns/100ps
`default_nettype none
module gszcr_host_model (
    // Clock
    input  wire logic       clk_sys_i,
    // Register port toward the bank
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic [7:0]      reg_addr_o,
    output logic [7:0]      reg_wdata_o,
    input  wire logic [7:0] reg_rdata_i
);
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
    end

    // Idle address and data show the inverse of the last value, so a bank
    // that samples outside its strobe picks up garbage, not a lucky copy.
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_sys_i);
        reg_wr_o = 1'b1;
        reg_addr_o = addr;
        reg_wdata_o = data;
        @(negedge clk_sys_i);
        reg_wr_o = 1'b0;
        reg_addr_o = ~addr;
        reg_wdata_o = ~data;
    endtask

    // Read data is taken one full cycle after the strobe is dropped.
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk_sys_i);
        reg_rd_o = 1'b1;
        reg_addr_o = addr;
        @(negedge clk_sys_i);
        reg_rd_o = 1'b0;
        reg_addr_o = ~addr;
        @(negedge clk_sys_i);
        data = reg_rdata_i;
    endtask
endmodule
`default_nettype wire

// ### testbench/gszcr_regs_tb.sv
// Self-checking bench for the configuration register bank.
`timescale 1ns/100ps
`default_nettype none
module gszcr_regs_tb;
    logic       clk_sys, reset, wr, rd, done, above;
    logic [7:0] addr, wdata, rdata, pins, pin_out, pin_oe, rv;
    logic [7:0] scan_en;
    logic [3:0] chan;
    logic [1:0] method;
    logic       chan_valid, run, zero_crossing_detect;
    int         n_fail = 0;
    int         n_compared = 0;
    int         n_cycles = 0;
    logic [7:0] all_addr [9] = '{8'h05, 8'h07, 8'h0B, 8'h0D, 8'h0F,
                                 8'h10, 8'h11, 8'h12, 8'h20};
    logic [7:0] rw_addr [6] = '{8'h05, 8'h07, 8'h0B, 8'h0F, 8'h11, 8'h12};

    gszcr_regs #(.CHANNELS(8)) dut (
        .clk_sys_i(clk_sys), .reset_i(reset), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .pin_level_i(pins), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
        .conv_done_i(done), .conv_above_i(above), .conv_channel_o(chan),
        .conv_channel_valid_o(chan_valid), .scan_method_o(method),
        .scan_run_o(run), .scan_channel_enable_o(scan_en),
        .zero_crossing_detect_o(zero_crossing_detect));

    gszcr_host_model u_host (
        .clk_sys_i(clk_sys), .reg_wr_o(wr), .reg_rd_o(rd),
        .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_rdata_i(rdata));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] expected);
        n_compared++;
        if (seen !== expected) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h expected=%h",
                     $time, seen, expected);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic do_reset();
        @(negedge clk_sys);
        reset = 1'b1;
        settle(2);
        reset = 1'b0;
    endtask

    // One finished conversion; the comparator line is garbage afterwards.
    task automatic convert(input logic is_above);
        @(negedge clk_sys);
        done = 1'b1;
        above = is_above;
        @(negedge clk_sys);
        done = 1'b0;
        above = ~is_above;
        settle(2);
    endtask

    always @(posedge clk_sys) begin
        n_cycles++;
        if (n_cycles == 20000) begin
            n_fail++;
            final_report();
        end
    end

    initial begin
        reset = 1'b1;
        pins = 8'h00;
        done = 1'b0;
        above = 1'b0;
        settle(2);
        reset = 1'b0;
        for (int i = 0; i < 9; i++) begin
            u_host.read_reg(all_addr[i], rv);
            check(rv, 8'h00);
        end
        for (int i = 0; i < 6; i++) begin
            u_host.write_reg(rw_addr[i], 8'hA5);
            u_host.read_reg(rw_addr[i], rv);
            check(rv, 8'hA5);
        end
        do_reset();
        u_host.write_reg(8'h05, 8'hFF);
        u_host.write_reg(8'h07, 8'h0F);
        u_host.write_reg(8'h0B, 8'h5A);
        settle(2);
        check(pin_oe, 8'h0F);
        check(pin_out & 8'h0F, 8'h0A);
        u_host.write_reg(8'h05, 8'h33);
        settle(2);
        check(pin_oe, 8'h03);
        check(pin_out & 8'h03, 8'h02);
        pins = 8'hA5;
        u_host.read_reg(8'h0D, rv);
        check(rv, 8'hA5);
        u_host.write_reg(8'h0D, 8'hFF);
        pins = 8'h3C;
        u_host.read_reg(8'h0D, rv);
        check(rv, 8'h3C);
        u_host.write_reg(8'h20, 8'hFF);
        u_host.read_reg(8'h20, rv);
        check(rv, 8'h00);
        u_host.read_reg(8'h0B, rv);
        check(rv, 8'h5A);
        u_host.write_reg(8'h10, 8'hFF);
        u_host.read_reg(8'h10, rv);
        check(rv, 8'h13);
        for (int m = 0; m < 4; m++) begin
            u_host.write_reg(8'h10, 8'(m));
            settle(2);
            check({6'h00, method}, 8'(m));
        end
        // Analog-only channels so the scan picks are valid; manual code 8 is not.
        u_host.write_reg(8'h05, 8'h00);
        u_host.write_reg(8'h12, 8'h0A);
        u_host.write_reg(8'h10, 8'h11);
        settle(2);
        check({7'h00, run}, 8'h01);
        check(scan_en, 8'h0A);
        check({7'h00, chan_valid}, 8'h01);
        check({4'h0, chan}, 8'h01);
        convert(1'b0);
        check({4'h0, chan}, 8'h03);
        convert(1'b0);
        check({4'h0, chan}, 8'h01);
        u_host.write_reg(8'h10, 8'h01);
        settle(2);
        check({7'h00, run}, 8'h00);
        u_host.write_reg(8'h10, 8'h10);
        settle(2);
        check({7'h00, run}, 8'h00);
        u_host.write_reg(8'h10, 8'h00);
        for (int c = 0; c < 9; c++) begin
            u_host.write_reg(8'h11, 8'(c));
            settle(2);
            check({7'h00, chan_valid}, (c < 8) ? 8'h01 : 8'h00);
            if (c < 8) check({4'h0, chan}, 8'(c));
        end
        // Blanking: plain count, then the multiplied count at its boundary.
        pins = 8'h00;
        for (int k = 0; k < 2; k++) begin
            do_reset();
            u_host.write_reg(8'h11, 8'h11);
            u_host.write_reg(8'h0F, (k == 0) ? 8'h02 : 8'h81);
            convert(1'b1);
            check({7'h00, zero_crossing_detect}, 8'h01);
            // The last blanked conversion flips the level; the next one
            // must raise an event again.
            repeat ((k == 0) ? 1 : 7) convert(1'b1);
            convert(1'b0);
            check({7'h00, zero_crossing_detect}, 8'h01);
            convert(1'b1);
            check({7'h00, zero_crossing_detect}, 8'h00);
        end
        do_reset();
        u_host.write_reg(8'h05, 8'h08);
        u_host.write_reg(8'h07, 8'h00);
        u_host.write_reg(8'h11, 8'h30);
        settle(2);
        pins = 8'h08;
        settle(4);
        check({7'h00, zero_crossing_detect}, 8'h01);
        final_report();
    end
endmodule
`default_nettype wire
